/* rtl/ebtd_top.sv */
// What this block does
// - address match compares only mask-selected bits
// - data comparator address is word; any byte matches
// - data address compare ignores top two bits
// - address for fetch and data; data only data
// - write data compare width follows access size
// - one trace enable per unit, serviced checked
// - unit trace enables need trace mode or trigger
// - reserved field encoding acts like reset value
// - unit match uses masked value and mask fields
// - action field: off, break, reserved, watch; event
// - unit register write break halts after instruction
// - host request at service start halts before thread
// - link request at service start halts before thread
// - match latch at service start halts before thread
// - transition latch at service start halts before thread
// - injection writes while running are dropped
// - halted injection executes word; finish ignored
// - comparator and source breakpoints stop before the triggering instruction
// - slot switch data accesses never reach comparators; fetches still do
`timescale 1ns/1ps
`include "ebtd_regs.svh"
module ebtd_top #(
   parameter int ADDR_W = 8,
   parameter logic [31:0] FINISH_MASK = 32'hFFFF_0000,
   parameter logic [31:0] FINISH_VALUE = 32'hFFFF_0000
) (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic [2:0] ARPROT,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic FETCH_VALID,
   input wire logic [13:0] FETCH_ADDR,
   input wire logic MEM_VALID,
   input wire logic MEM_WRITE,
   input wire logic [13:0] MEM_ADDR,
   input wire logic [1:0] MEM_SIZE,
   input wire logic [31:0] MEM_WDATA,
   input wire logic SLOT_SWITCH_PHASE,
   input wire logic SERVICE_START,
   input wire logic [4:0] SERVICED_UNIT_REGISTER,
   input wire logic UNIT_REG_WRITE,
   input wire logic HOST_REQUEST,
   input wire logic LINK_REQUEST,
   input wire logic MATCH_LATCH_FIRST,
   input wire logic MATCH_LATCH_SECOND_BRANCH,
   input wire logic TRANSITION_LATCH_FIRST_BRANCH,
   input wire logic TRANSITION_LATCH_SECOND_BRANCH,
   input wire logic TRACE_MODE_FIELD_ON,
   input wire logic ENGINE_HALTED,
   output logic HALT_BEFORE_EXEC,
   output logic HALT_AFTER_EXEC,
   output logic EVENT_OUT_PIN,
   output logic WATCH_TRIGGER,
   output logic TRACE_ENABLE,
   output logic INJECT_VALID,
   output logic [31:0] INJECT_WORD
);
   localparam int NUM_CMP = 2;
   localparam int NUM_SRC = 4;

   if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_check
      $error("ebtd_top: ADDR_W must lie between 6 and 32");
   end

   logic [31:0] bp_address_compare [NUM_CMP];
   logic [31:0] bp_data_compare [NUM_CMP];
   logic [31:0] channel_trace_enables;
   logic [31:0] service_event_break_control;
   logic [31:0] comparator_control;
   logic trace_flag;

   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] rd_value;
   logic rd_known;

   logic [NUM_CMP-1:0] cmp_hit;
   logic [NUM_CMP-1:0] cmp_break;
   logic [NUM_CMP-1:0] cmp_watch;
   logic [NUM_CMP-1:0] cmp_event;
   logic [NUM_SRC-1:0] src_cond;
   logic [NUM_SRC-1:0] src_break;
   logic [NUM_SRC-1:0] src_watch;
   logic [NUM_SRC-1:0] src_event;
   logic unit_match;
   logic unitwr_fire;
   logic [4:0] serviced_match_value;
   logic [4:0] serviced_match_mask;
   ebtd_pkg::ebtd_action_t unitwr_act;
   logic any_watch;
   logic any_event;

   function automatic ebtd_pkg::ebtd_action_t decode_action(input logic [2:0] field);
      case (field[2:1])
         2'b01: decode_action = ebtd_pkg::EBTD_ACT_BREAK;
         2'b11: decode_action = ebtd_pkg::EBTD_ACT_WATCH;
         default: decode_action = ebtd_pkg::EBTD_ACT_OFF;
      endcase
   endfunction

   function automatic logic reg_at(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
      reg_at = ((addr >> 2) == (ADDR_W'(off) >> 2));
   endfunction

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      merge_bytes = res;
   endfunction

   // axi4-lite write side: address and data may arrive in either order
   assign AWREADY = !aw_held && !BVALID;
   assign WREADY = !w_held && !BVALID;
   assign wr_go = aw_held && w_held && !BVALID;
   assign wr_addr = aw_addr;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (AWVALID && AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= AWADDR;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (WVALID && WREADY) begin
         w_held <= 1'b1;
         w_data <= WDATA;
         w_strb <= WSTRB;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         BVALID <= 1'b0;
         BRESP <= `EBTD_RESP_OKAY;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         BRESP <= (reg_at(wr_addr, `EBTD_OFF_STATUS) || !rd_map(wr_addr)) ?
            `EBTD_RESP_SLVERR : `EBTD_RESP_OKAY;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   function automatic logic rd_map(input logic [ADDR_W-1:0] addr);
      rd_map = reg_at(addr, `EBTD_OFF_ADDR_CMP1) || reg_at(addr, `EBTD_OFF_ADDR_CMP2) ||
         reg_at(addr, `EBTD_OFF_DATA_CMP1) || reg_at(addr, `EBTD_OFF_DATA_CMP2) ||
         reg_at(addr, `EBTD_OFF_TRACE_EN) || reg_at(addr, `EBTD_OFF_SVC_CTRL) ||
         reg_at(addr, `EBTD_OFF_INJECT) || reg_at(addr, `EBTD_OFF_CMP_CTRL) ||
         reg_at(addr, `EBTD_OFF_STATUS);
   endfunction

   // comparator registers
   for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp_regs
      always_ff @(posedge CLOCK) begin
         if (SRST) begin
            bp_address_compare[c] <= `EBTD_RESET_VALUE;
            bp_data_compare[c] <= `EBTD_RESET_VALUE;
         end else if (wr_go) begin
            if (reg_at(wr_addr, 8'(`EBTD_OFF_ADDR_CMP1 + 4 * c))) begin
               bp_address_compare[c] <= merge_bytes(bp_address_compare[c], w_data, w_strb);
            end
            if (reg_at(wr_addr, 8'(`EBTD_OFF_DATA_CMP1 + 4 * c))) begin
               bp_data_compare[c] <= merge_bytes(bp_data_compare[c], w_data, w_strb);
            end
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         channel_trace_enables <= `EBTD_RESET_VALUE;
         service_event_break_control <= `EBTD_RESET_VALUE;
         comparator_control <= `EBTD_RESET_VALUE;
      end else if (wr_go) begin
         if (reg_at(wr_addr, `EBTD_OFF_TRACE_EN)) begin
            channel_trace_enables <= merge_bytes(channel_trace_enables, w_data, w_strb);
         end
         if (reg_at(wr_addr, `EBTD_OFF_SVC_CTRL)) begin
            service_event_break_control <= merge_bytes(service_event_break_control, w_data,
               w_strb);
         end
         if (reg_at(wr_addr, `EBTD_OFF_CMP_CTRL)) begin
            comparator_control <= merge_bytes(comparator_control, w_data, w_strb) &
               ~(32'h1 << `EBTD_TRACE_CLR_BIT);
         end
      end
   end

   // microinstruction injection; a running engine never sees it
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         INJECT_VALID <= 1'b0;
         INJECT_WORD <= `EBTD_RESET_VALUE;
      end else begin
         INJECT_VALID <= 1'b0;
         if (wr_go && reg_at(wr_addr, `EBTD_OFF_INJECT) && ENGINE_HALTED) begin
            INJECT_WORD <= merge_bytes(32'h0000_0000, w_data, w_strb);
            // a thread finish would end debug in mid-air, so it is dropped
            INJECT_VALID <= ((w_data & FINISH_MASK) != FINISH_VALUE);
         end
      end
   end

   // axi4-lite read side, one cycle to answer
   assign ARREADY = !RVALID;

   always_comb begin
      rd_value = 32'h0000_0000;
      rd_known = rd_map(ARADDR);
      for (int c = 0; c < NUM_CMP; c++) begin
         if (reg_at(ARADDR, 8'(`EBTD_OFF_ADDR_CMP1 + 4 * c))) begin
            rd_value = bp_address_compare[c];
         end
         if (reg_at(ARADDR, 8'(`EBTD_OFF_DATA_CMP1 + 4 * c))) begin
            rd_value = bp_data_compare[c];
         end
      end
      if (reg_at(ARADDR, `EBTD_OFF_TRACE_EN)) begin
         rd_value = channel_trace_enables;
      end
      if (reg_at(ARADDR, `EBTD_OFF_SVC_CTRL)) begin
         rd_value = service_event_break_control;
      end
      if (reg_at(ARADDR, `EBTD_OFF_CMP_CTRL)) begin
         rd_value = comparator_control;
      end
      if (reg_at(ARADDR, `EBTD_OFF_STATUS)) begin
         rd_value = {23'h0, SERVICED_UNIT_REGISTER, 2'h0, trace_flag, ENGINE_HALTED};
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         RVALID <= 1'b0;
         RDATA <= `EBTD_RESET_VALUE;
         RRESP <= `EBTD_RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA <= rd_value;
         RRESP <= rd_known ? `EBTD_RESP_OKAY : `EBTD_RESP_SLVERR;
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // address and data comparators
   ebtd_obs_if obs ();
   assign obs.fetch_valid = FETCH_VALID;
   assign obs.fetch_addr = FETCH_ADDR;
   assign obs.mem_valid = MEM_VALID;
   assign obs.mem_write = MEM_WRITE;
   assign obs.mem_addr = MEM_ADDR;
   assign obs.mem_size = MEM_SIZE;
   assign obs.mem_wdata = MEM_WDATA;
   assign obs.slot_switch = SLOT_SWITCH_PHASE;

   for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
      localparam int BASE = c * `EBTD_CMP_STRIDE;
      ebtd_pkg::ebtd_action_t act;
      ebtd_comparator u_cmp (
         .obs(obs),
         .addr_cfg(bp_address_compare[c]),
         .data_cfg(bp_data_compare[c]),
         .operand(comparator_control[BASE + `EBTD_CMP_OP_LSB +: 3]),
         .hit(cmp_hit[c])
      );
      assign act = decode_action(comparator_control[BASE +: `EBTD_ACT_W]);
      assign cmp_break[c] = cmp_hit[c] && act == ebtd_pkg::EBTD_ACT_BREAK;
      assign cmp_watch[c] = cmp_hit[c] && act == ebtd_pkg::EBTD_ACT_WATCH;
      assign cmp_event[c] = (cmp_break[c] || cmp_watch[c]) && comparator_control[BASE];
   end

   // serviced unit match and service start sources
   assign serviced_match_value = service_event_break_control[`EBTD_SERVICED_MATCH_VALUE_MSB:`EBTD_SERVICED_MATCH_VALUE_LSB];
   assign serviced_match_mask = service_event_break_control[`EBTD_SERVICED_MATCH_MASK_MSB:`EBTD_SERVICED_MATCH_MASK_LSB];
   assign unit_match = ((serviced_match_value & serviced_match_mask) ==
      (SERVICED_UNIT_REGISTER & serviced_match_mask));

   assign src_cond[0] = HOST_REQUEST;
   assign src_cond[1] = LINK_REQUEST;
   assign src_cond[2] = MATCH_LATCH_FIRST || MATCH_LATCH_SECOND_BRANCH;
   assign src_cond[3] = TRANSITION_LATCH_FIRST_BRANCH || TRANSITION_LATCH_SECOND_BRANCH;

   for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      localparam int LSB = `EBTD_SRC_LSB + s * `EBTD_ACT_W;
      ebtd_pkg::ebtd_action_t act;
      logic fire;
      assign act = decode_action(service_event_break_control[LSB +: `EBTD_ACT_W]);
      assign fire = SERVICE_START && unit_match && src_cond[s];
      assign src_break[s] = fire && act == ebtd_pkg::EBTD_ACT_BREAK;
      assign src_watch[s] = fire && act == ebtd_pkg::EBTD_ACT_WATCH;
      assign src_event[s] = (src_break[s] || src_watch[s]) && service_event_break_control[LSB];
   end

   assign unitwr_act = decode_action(
      service_event_break_control[`EBTD_UNITWR_LSB +: `EBTD_ACT_W]);
   assign unitwr_fire = UNIT_REG_WRITE && unit_match;

   // halts are combinational so the engine can stop ahead of the instruction
   assign HALT_BEFORE_EXEC = (|cmp_break) || (|src_break);
   assign HALT_AFTER_EXEC = unitwr_fire && unitwr_act == ebtd_pkg::EBTD_ACT_BREAK;

   assign any_watch = (|cmp_watch) || (|src_watch) ||
      (unitwr_fire && unitwr_act == ebtd_pkg::EBTD_ACT_WATCH);
   assign any_event = (|cmp_event) || (|src_event) ||
      (unitwr_fire && unitwr_act != ebtd_pkg::EBTD_ACT_OFF &&
      service_event_break_control[`EBTD_UNITWR_LSB]);

   // watchpoints only report; they never reach the halt outputs
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         WATCH_TRIGGER <= 1'b0;
         EVENT_OUT_PIN <= 1'b0;
      end else begin
         WATCH_TRIGGER <= any_watch;
         EVENT_OUT_PIN <= any_event;
      end
   end

   // trigger-started trace; a new trigger beats a clear in the same cycle
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         trace_flag <= 1'b0;
      end else if (any_watch) begin
         trace_flag <= 1'b1;
      end else if (wr_go && reg_at(wr_addr, `EBTD_OFF_CMP_CTRL) && w_strb[3] &&
            w_data[`EBTD_TRACE_CLR_BIT]) begin
         trace_flag <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         TRACE_ENABLE <= 1'b0;
      end else begin
         TRACE_ENABLE <= (TRACE_MODE_FIELD_ON || trace_flag) &&
            channel_trace_enables[SERVICED_UNIT_REGISTER];
      end
   end
endmodule

/* rtl/ebtd_regs.svh */
`ifndef EBTD_REGS_SVH
`define EBTD_REGS_SVH

// byte offsets
`define EBTD_OFF_ADDR_CMP1 8'h00
`define EBTD_OFF_ADDR_CMP2 8'h04
`define EBTD_OFF_DATA_CMP1 8'h08
`define EBTD_OFF_DATA_CMP2 8'h0C
`define EBTD_OFF_TRACE_EN 8'h10
`define EBTD_OFF_SVC_CTRL 8'h14
`define EBTD_OFF_INJECT 8'h18
`define EBTD_OFF_CMP_CTRL 8'h1C
`define EBTD_OFF_STATUS 8'h20

`define EBTD_RESET_VALUE 32'h0000_0000

// address compare register fields
`define EBTD_AMASK_LSB 0
`define EBTD_AMASK_MSB 13
`define EBTD_AVAL_LSB 16
`define EBTD_AVAL_MSB 29

// service event break control fields
`define EBTD_SERVICED_MATCH_VALUE_LSB 3
`define EBTD_SERVICED_MATCH_VALUE_MSB 7
`define EBTD_SERVICED_MATCH_MASK_LSB 11
`define EBTD_SERVICED_MATCH_MASK_MSB 15
`define EBTD_UNITWR_LSB 17
`define EBTD_SRC_LSB 20
`define EBTD_ACT_W 3

// comparator control fields
`define EBTD_CMP_STRIDE 8
`define EBTD_CMP_OP_LSB 3
`define EBTD_TRACE_CLR_BIT 31

// comparator operand encodings
`define EBTD_OP_FETCH 3'h1
`define EBTD_OP_DADDR 3'h2
`define EBTD_OP_WDATA 3'h3
`define EBTD_OP_WBOTH 3'h4

// access size encodings
`define EBTD_SIZE_8 2'h0
`define EBTD_SIZE_24 2'h1
`define EBTD_SIZE_32 2'h2

`define EBTD_RESP_OKAY 2'h0
`define EBTD_RESP_SLVERR 2'h2

`endif

/* rtl/ebtd_pkg.sv */
package ebtd_pkg;
   typedef enum logic [1:0] {
      EBTD_ACT_OFF,
      EBTD_ACT_BREAK,
      EBTD_ACT_WATCH
   } ebtd_action_t;
endpackage

/* rtl/ebtd_obs_if.sv */
`timescale 1ns/1ps
interface ebtd_obs_if;
   logic fetch_valid;
   logic [13:0] fetch_addr;
   logic mem_valid;
   logic mem_write;
   logic [13:0] mem_addr;
   logic [1:0] mem_size;
   logic [31:0] mem_wdata;
   logic slot_switch;
   modport src (output fetch_valid, fetch_addr, mem_valid, mem_write, mem_addr, mem_size,
      mem_wdata, slot_switch);
   modport cmp (input fetch_valid, fetch_addr, mem_valid, mem_write, mem_addr, mem_size,
      mem_wdata, slot_switch);
endinterface

/* rtl/ebtd_comparator.sv */
`timescale 1ns/1ps
`include "ebtd_regs.svh"
module ebtd_comparator (
   ebtd_obs_if.cmp obs,
   input wire logic [31:0] addr_cfg,
   input wire logic [31:0] data_cfg,
   input wire logic [2:0] operand,
   output logic hit
);
   logic [13:0] bp_address_mask;
   logic [13:0] bp_address_value;
   logic fetch_hit;
   logic daddr_hit;
   logic wdata_hit;
   logic mem_seen;

   assign bp_address_mask = addr_cfg[`EBTD_AMASK_MSB:`EBTD_AMASK_LSB];
   assign bp_address_value = addr_cfg[`EBTD_AVAL_MSB:`EBTD_AVAL_LSB];

   // only fetch matching uses all fourteen compare bits
   assign fetch_hit = obs.fetch_valid &&
      ((bp_address_value & bp_address_mask) == (obs.fetch_addr & bp_address_mask));

   // word compare, so any byte inside the word matches; top two bits dropped
   assign daddr_hit = ((bp_address_value[11:0] & bp_address_mask[11:0]) ==
      (obs.mem_addr[13:2] & bp_address_mask[11:0]));

   // slot switch data accesses never reach the comparators; fetch matching is not gated
   assign mem_seen = obs.mem_valid && !obs.slot_switch;

   always_comb begin
      case (obs.mem_size)
         `EBTD_SIZE_8: wdata_hit = (data_cfg[31:24] == obs.mem_wdata[31:24]);
         `EBTD_SIZE_24: wdata_hit = (data_cfg[23:0] == obs.mem_wdata[23:0]);
         `EBTD_SIZE_32: wdata_hit = (data_cfg == obs.mem_wdata);
         default: wdata_hit = 1'b0;
      endcase
   end

   always_comb begin
      case (operand)
         `EBTD_OP_FETCH: hit = fetch_hit;
         `EBTD_OP_DADDR: hit = mem_seen && daddr_hit;
         `EBTD_OP_WDATA: hit = mem_seen && obs.mem_write && wdata_hit;
         `EBTD_OP_WBOTH: hit = mem_seen && obs.mem_write && wdata_hit && daddr_hit;
         default: hit = 1'b0;
      endcase
   end
endmodule

/* tb/ebtd_top_properties.sv */
`timescale 1ns/1ps
module ebtd_checker (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic BVALID,
   input wire logic FETCH_VALID,
   input wire logic MEM_VALID,
   input wire logic SLOT_SWITCH_PHASE,
   input wire logic SERVICE_START,
   input wire logic UNIT_REG_WRITE,
   input wire logic ENGINE_HALTED,
   input wire logic HALT_BEFORE_EXEC,
   input wire logic HALT_AFTER_EXEC,
   input wire logic EVENT_OUT_PIN,
   input wire logic WATCH_TRIGGER,
   input wire logic INJECT_VALID
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   property p_after_src;
      HALT_AFTER_EXEC |-> UNIT_REG_WRITE;
   endproperty
   a_after_src: assert property (p_after_src) else $error("late halt without unit write");
   property p_before_src;
      HALT_BEFORE_EXEC |-> FETCH_VALID || MEM_VALID || SERVICE_START;
   endproperty
   a_before_src: assert property (p_before_src) else $error("early halt without cause");
   property p_slot;
      SLOT_SWITCH_PHASE && !FETCH_VALID && !SERVICE_START |-> !HALT_BEFORE_EXEC;
   endproperty
   a_slot: assert property (p_slot) else $error("halt during slot switch");
   property p_watch;
      WATCH_TRIGGER |-> $past(FETCH_VALID || MEM_VALID || SERVICE_START || UNIT_REG_WRITE);
   endproperty
   a_watch: assert property (p_watch) else $error("watch without prior event");
   property p_event_cause;
      EVENT_OUT_PIN |-> $past(FETCH_VALID || MEM_VALID || SERVICE_START || UNIT_REG_WRITE);
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("event pin without cause");
   property p_inject;
      INJECT_VALID |-> $past(ENGINE_HALTED) && $rose(BVALID);
   endproperty
   a_inject: assert property (p_inject) else $error("injection while running");
   property p_inject_once;
      INJECT_VALID |=> !INJECT_VALID;
   endproperty
   a_inject_once: assert property (p_inject_once) else $error("injection pulse too long");
   property p_rdone;
      RVALID && RREADY |=> !RVALID;
   endproperty
   a_rdone: assert property (p_rdone) else $error("read answer not retired");
   c_after: cover property (HALT_AFTER_EXEC);
   c_watch: cover property (WATCH_TRIGGER);
   c_inject: cover property (INJECT_VALID);
endmodule
bind ebtd_top ebtd_checker i_ebtd_checker (.*);

/* tb/ebtd_tool.sv */
`timescale 1ns/1ps
module ebtd_tool (
   input wire logic CLOCK,
   output logic [7:0] AWADDR,
   output logic AWVALID,
   input wire logic AWREADY,
   output logic [31:0] WDATA,
   output logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   output logic BREADY,
   output logic [7:0] ARADDR,
   output logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   output logic RREADY
);
   initial begin
      {AWADDR, ARADDR, WDATA} = '0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
   end
   // each channel held until its own ready; no cycle count assumed for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (AWREADY) begin
            AWVALID <= 1'b0;
         end
         if (WREADY) begin
            WVALID <= 1'b0;
         end
      end while (!BVALID);
      r = BRESP;
      BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (ARREADY) begin
            ARVALID <= 1'b0;
         end
      end while (!RVALID);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask
   // a blind injection would be dropped, so look at the halted bit first
   task automatic inj(input logic [31:0] w, output logic [1:0] r);
      logic [31:0] s;
      rd(8'h20, s, r);
      if (s[0]) begin
         wr(8'h18, w, r);
      end
   endtask
endmodule

/* tb/ebtd_top_tb.sv */
`timescale 1ns/1ps
module ebtd_top_tb;
   logic CLOCK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
   logic RVALID, RREADY, FETCH_VALID, MEM_VALID, MEM_WRITE, SLOT_SWITCH_PHASE, SERVICE_START;
   logic UNIT_REG_WRITE, HOST_REQUEST, LINK_REQUEST, MATCH_LATCH_FIRST, MATCH_LATCH_SECOND_BRANCH;
   logic TRANSITION_LATCH_FIRST_BRANCH, TRANSITION_LATCH_SECOND_BRANCH, TRACE_MODE_FIELD_ON;
   logic ENGINE_HALTED, HALT_BEFORE_EXEC, HALT_AFTER_EXEC, EVENT_OUT_PIN, WATCH_TRIGGER;
   logic TRACE_ENABLE, INJECT_VALID;
   logic [7:0] AWADDR, ARADDR;
   logic [2:0] AWPROT, ARPROT;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, MEM_SIZE;
   logic [31:0] WDATA, RDATA, MEM_WDATA, INJECT_WORD, d;
   logic [13:0] FETCH_ADDR, MEM_ADDR;
   logic [4:0] SERVICED_UNIT_REGISTER;
   logic [1:0] r;
   int err_count = 0, n_checks = 0, cyc = 0, inj_n = 0;
   ebtd_top i_ebtd_top (.*);
   ebtd_tool i_ebtd_tool (.*);
   initial begin
      CLOCK = 1'b0;
      forever begin
         #50 CLOCK = ~CLOCK;
      end
   end
   task automatic summarize();
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // a hang would otherwise pass silently
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (INJECT_VALID === 1'b1) begin
         inj_n <= inj_n + 1;
      end
      if (cyc == 5000) begin
         err_count = err_count + 1;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // e = {early halt, late halt, watch, event pin}
   task automatic fire(input logic [3:0] e);
      @(negedge CLOCK);
      chk(HALT_BEFORE_EXEC, e[3]);
      chk(HALT_AFTER_EXEC, e[2]);
      @(posedge CLOCK);
      {FETCH_VALID, MEM_VALID, SLOT_SWITCH_PHASE, SERVICE_START, UNIT_REG_WRITE} <= 5'h00;
      @(negedge CLOCK);
      chk(WATCH_TRIGGER, e[1]);
      chk(EVENT_OUT_PIN, e[0]);
   endtask
   // k = {fetch, access, write, slot switch, size}
   task automatic mem(input logic [7:0] c, input logic [13:0] fa, input logic [5:0] k,
         input logic [13:0] ma, input logic [31:0] wd, input logic [3:0] e);
      i_ebtd_tool.wr(8'h1C, {24'h00_0000, c}, r);
      {FETCH_VALID, MEM_VALID, MEM_WRITE, SLOT_SWITCH_PHASE, MEM_SIZE} <= k;
      FETCH_ADDR <= fa;
      MEM_ADDR <= ma;
      MEM_WDATA <= wd;
      fire(e);
   endtask
   task automatic svc(input logic [31:0] c, input logic [4:0] u, input logic [7:0] f,
         input logic [3:0] e);
      i_ebtd_tool.wr(8'h14, c, r);
      SERVICED_UNIT_REGISTER <= u;
      {SERVICE_START, UNIT_REG_WRITE, HOST_REQUEST, LINK_REQUEST, MATCH_LATCH_FIRST,
         MATCH_LATCH_SECOND_BRANCH, TRANSITION_LATCH_FIRST_BRANCH,
         TRANSITION_LATCH_SECOND_BRANCH} <= f;
      fire(e);
   endtask
   task automatic trc(input logic m, input logic [4:0] u, input logic e);
      @(posedge CLOCK);
      TRACE_MODE_FIELD_ON <= m;
      SERVICED_UNIT_REGISTER <= u;
      @(posedge CLOCK);
      @(negedge CLOCK);
      chk(TRACE_ENABLE, e);
   endtask
   initial begin
      SRST = 1'b1;
      {AWPROT, ARPROT, WSTRB} = 10'h00F;
      {FETCH_ADDR, MEM_ADDR, MEM_SIZE, MEM_WDATA, SERVICED_UNIT_REGISTER} = '0;
      {FETCH_VALID, MEM_VALID, MEM_WRITE, SLOT_SWITCH_PHASE, SERVICE_START} = 5'h00;
      {UNIT_REG_WRITE, HOST_REQUEST, LINK_REQUEST, MATCH_LATCH_FIRST} = 4'h0;
      {MATCH_LATCH_SECOND_BRANCH, TRANSITION_LATCH_FIRST_BRANCH} = 2'h0;
      {TRANSITION_LATCH_SECOND_BRANCH, TRACE_MODE_FIELD_ON, ENGINE_HALTED} = 3'h0;
      repeat (12) @(posedge CLOCK);
      SRST <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         i_ebtd_tool.rd(8'(i * 4), d, r);
         chk(d, 32'h0000_0000);
         i_ebtd_tool.wr(8'(i * 4), 32'h2A4A_2A58 + i, r);
         i_ebtd_tool.rd(8'(i * 4), d, r);
         chk(d, 32'h2A4A_2A58 + i);
      end
      i_ebtd_tool.rd(8'h24, d, r);
      chk(d, 32'h0);
      chk(r, 2'h2);
      i_ebtd_tool.rd(8'h18, d, r);
      chk(d, 32'h0);
      chk(r, 2'h0);
      i_ebtd_tool.wr(8'h20, 32'h0000_0001, r);
      chk(r, 2'h2);
      i_ebtd_tool.wr(8'h00, 32'h3123_3FFF, r);
      i_ebtd_tool.wr(8'h08, 32'h1122_3344, r);
      mem(8'h13, 14'h0000, 6'h12, 14'h048E, 32'h0, 4'b1001);
      mem(8'h13, 14'h0000, 6'h12, 14'h0490, 32'h0, 4'b0000);
      mem(8'h13, 14'h0000, 6'h16, 14'h048E, 32'h0, 4'b0000);
      mem(8'h13, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b0000);
      mem(8'h0B, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b1001);
      mem(8'h0B, 14'h0123, 6'h20, 14'h0000, 32'h0, 4'b0000);
      mem(8'h1B, 14'h0000, 6'h18, 14'h0000, 32'h11FF_FFFF, 4'b1001);
      mem(8'h1B, 14'h0000, 6'h19, 14'h0000, 32'hFF22_3344, 4'b1001);
      mem(8'h1B, 14'h0000, 6'h19, 14'h0000, 32'h0022_3345, 4'b0000);
      mem(8'h1B, 14'h0000, 6'h1A, 14'h0000, 32'h1122_3344, 4'b1001);
      mem(8'h1B, 14'h0000, 6'h1A, 14'h0000, 32'h1122_3345, 4'b0000);
      mem(8'h1B, 14'h0000, 6'h12, 14'h0000, 32'h1122_3344, 4'b0000);
      mem(8'h1B, 14'h3123, 6'h20, 14'h0000, 32'h1122_3344, 4'b0000);
      mem(8'h0A, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b1000);
      mem(8'h0D, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b0000);
      mem(8'h09, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b0000);
      i_ebtd_tool.wr(8'h00, 32'h3123_3FF0, r);
      mem(8'h0B, 14'h312F, 6'h20, 14'h0000, 32'h0, 4'b1001);
      mem(8'h0F, 14'h3123, 6'h20, 14'h0000, 32'h0, 4'b0011);
      mem(8'h23, 14'h0000, 6'h1A, 14'h0480, 32'h1122_3344, 4'b1001);
      mem(8'h23, 14'h0000, 6'h1A, 14'h0500, 32'h1122_3344, 4'b0000);
      svc(32'h0030_F828, 5'd5, 8'hA0, 4'b1001);
      svc(32'h0030_F828, 5'd4, 8'hA0, 4'b0000);
      svc(32'h0030_F828, 5'd5, 8'h20, 4'b0000);
      svc(32'h0030_F828, 5'd5, 8'h80, 4'b0000);
      svc(32'h0030_F028, 5'd4, 8'hA0, 4'b1001);
      svc(32'h0100_F828, 5'd5, 8'h90, 4'b1000);
      svc(32'h0C00_F828, 5'd5, 8'h84, 4'b1001);
      svc(32'h0C00_F828, 5'd5, 8'h88, 4'b1001);
      svc(32'hE000_F828, 5'd5, 8'h81, 4'b0011);
      svc(32'hE000_F828, 5'd5, 8'h82, 4'b0011);
      svc(32'h0006_F828, 5'd5, 8'h40, 4'b0101);
      svc(32'h0050_F828, 5'd5, 8'hA0, 4'b0000);
      svc(32'h0010_F828, 5'd5, 8'hA0, 4'b0000);
      i_ebtd_tool.rd(8'h14, d, r);
      chk(d, 32'h0010_F828);
      i_ebtd_tool.wr(8'h10, 32'h0000_0020, r);
      trc(1'b0, 5'd5, 1'b1);
      trc(1'b0, 5'd4, 1'b0);
      i_ebtd_tool.wr(8'h1C, 32'h8000_0000, r);
      trc(1'b0, 5'd5, 1'b0);
      trc(1'b1, 5'd5, 1'b1);
      trc(1'b1, 5'd4, 1'b0);
      i_ebtd_tool.wr(8'h18, 32'h0000_1234, r);
      @(posedge CLOCK);
      chk({r, 30'(inj_n)}, 32'h0);
      ENGINE_HALTED <= 1'b1;
      i_ebtd_tool.inj(32'h0000_1234, r);
      @(posedge CLOCK);
      chk(inj_n, 1);
      chk(INJECT_WORD, 32'h0000_1234);
      i_ebtd_tool.inj(32'hFFFF_0001, r);
      @(posedge CLOCK);
      chk(inj_n, 1);
      summarize();
   end
endmodule
